// File: rss_pkg.sv
// Shared constants for the relay switch serial slave.
// Assumes a 50 MHz core clock; the serial clock is a separate domain.
package rss_pkg;

   // Channel and register layout
   localparam int unsigned CH_NUM    = 8;
   localparam int unsigned MODE_W    = 2;
   localparam int unsigned REG_W     = 16;
   localparam int unsigned OL_OFS    = 1;
   localparam int unsigned PF_OFS    = 0;
   localparam logic [15:0] MODE_RST  = 16'hffff;
   localparam logic [15:0] SR_RST    = 16'hffff;
   localparam logic        TER_RST   = 1'h1;

   // Mode codes of one channel field
   localparam logic [1:0]  MODE_STANDBY = 2'h0;
   localparam logic [1:0]  MODE_INPUT   = 2'h1;
   localparam logic [1:0]  MODE_ON      = 2'h2;
   localparam logic [1:0]  MODE_OFF     = 2'h3;

   // Frame length check: count wraps from MIN+UNIT-1 back to MIN
   localparam int unsigned FRAME_UNIT = 8;
   localparam int unsigned FRAME_MIN  = 16;
   localparam int unsigned CNT_W      = 5;
   localparam logic [4:0]  CNT_MIN    = 5'h10;
   localparam logic [4:0]  CNT_WRAP   = 5'h17;
   localparam logic [4:0]  CNT_FIRST  = 5'h01;

   // Detector qualification times
   localparam int unsigned CLK_MHZ      = 50;
   localparam int unsigned OVL_DELAY_NS = 3000;
   localparam int unsigned OL_DELAY_NS  = 30000;
   localparam int unsigned OVL_CYC      = (OVL_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned OL_CYC       = (OL_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DLY_W        = 11;

   // Frame tracking in the core domain
   typedef enum logic [2:0]
   {
      RSS_ST_IDLE  = 3'b001,
      RSS_ST_FRAME = 3'b010,
      RSS_ST_CHECK = 3'b100
   } rss_frame_e;

endpackage : rss_pkg

// File: rss_link_if.sv
// Signals passed between the core logic and the serial-clock logic.
// All words are quasi-static: each side changes them only while the
// other side is guaranteed not to look.
`timescale 1ns/1ps
interface rss_link_if
   import rss_pkg::*;
();
   logic [REG_W-1:0] diag_word;
   logic             transfer_fault_flag;
   logic [REG_W-1:0] rx_word;
   logic [CNT_W-1:0] bit_cnt;
   logic             start_tog;

   modport core (output diag_word, output transfer_fault_flag,
                 input rx_word, input bit_cnt, input start_tog);
   modport link (input diag_word, input transfer_fault_flag,
                 output rx_word, output bit_cnt, output start_tog);
endinterface : rss_link_if

// File: rss_link.sv
// Serial-clock side: shift register, frame bit counter and data out.
// Assumes SCLK is low at every CS edge, so CS acts as a frame qualifier.
`timescale 1ns/1ps
module rss_link
   import rss_pkg::*;
(
   // Serial pins
   input  wire logic sclk_i,
   input  wire logic cs_n_i,
   input  wire logic si_i,
   input  wire logic rst_i,
   // Core side
   rss_link_if.link  lnk,
   // Data out, three-state
   output logic      so_o,
   output logic      so_oe_o
);
   logic             idle_rst;
   logic             rise_fresh_q;
   logic             fall_fresh_q;
   logic             so_q;
   logic             tog_q;
   logic [REG_W-1:0] sr_q;
   logic [CNT_W-1:0] cnt_q;

   // Held in reset while deselected so no stray SCLK edge counts
   assign idle_rst = rst_i | cs_n_i;

   always_ff @(posedge sclk_i or posedge idle_rst)
   begin
      if (idle_rst)
         rise_fresh_q <= 1'b1;
      else
         rise_fresh_q <= 1'b0;
   end

   always_ff @(negedge sclk_i or posedge idle_rst)
   begin
      if (idle_rst)
         fall_fresh_q <= 1'b1;
      else
         fall_fresh_q <= 1'b0;
   end

   // Sample on the falling edge, MSB first; first sample loads the snapshot
   always_ff @(negedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
         sr_q <= SR_RST;
      else if (!cs_n_i)
         sr_q <= fall_fresh_q ? {lnk.diag_word[REG_W-2:0], si_i}
                              : {sr_q[REG_W-2:0], si_i};
   end

   // Count rising edges; the count survives CS rise for the core to check
   always_ff @(posedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_q <= '0;
         tog_q <= 1'b0;
         so_q  <= 1'b1;
      end
      else if (!cs_n_i)
      begin
         so_q <= rise_fresh_q ? lnk.diag_word[REG_W-1] : sr_q[REG_W-1];
         if (rise_fresh_q)
         begin
            cnt_q <= CNT_FIRST;
            tog_q <= ~tog_q;
         end
         else if (cnt_q == CNT_WRAP)
            cnt_q <= CNT_MIN;
         else
            cnt_q <= cnt_q + CNT_FIRST;
      end
   end

   // Error flag ORed with SI until the first rising edge, for daisy chains
   assign so_o    = rise_fresh_q ? (lnk.transfer_fault_flag | si_i) : so_q;
   assign so_oe_o = ~cs_n_i;

   assign lnk.rx_word   = sr_q;
   assign lnk.bit_cnt   = cnt_q;
   assign lnk.start_tog = tog_q;

endmodule : rss_link

// File: rss_channel.sv
// One output channel: mode decode, protection latch-off and flags.
// Assumes its event inputs are already synchronised and qualified.
`timescale 1ns/1ps
module rss_channel
   import rss_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Control and detectors
   input  wire logic [MODE_W-1:0] mode_i,
   input  wire logic              in_pin_i,
   input  wire logic              ovl_evt_i,
   input  wire logic              ot_evt_i,
   input  wire logic              ol_evt_i,
   // State
   output logic                   on_o,
   output logic                   diag_cur_o,
   output logic                   ol_flag_o,
   output logic                   pf_flag_o
);
   logic standby;
   logic demand;
   logic fault;

   assign standby = (mode_i == MODE_STANDBY);
   assign demand  = (mode_i == MODE_ON)
                  | ((mode_i == MODE_INPUT) & in_pin_i);
   assign fault   = ovl_evt_i | ot_evt_i;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         on_o       <= 1'b0;
         diag_cur_o <= 1'b0;
      end
      else
      begin
         on_o       <= demand & ~pf_flag_o & ~fault;
         diag_cur_o <= (mode_i == MODE_OFF)
                     | ((mode_i == MODE_INPUT) & ~demand);
      end
   end

   // Set wins; a clear comes only in standby, where only pf_flag can still set, while on_o holds from the cycle before
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pf_flag_o <= 1'b0;
         ol_flag_o <= 1'b0;
      end
      else
      begin
         if (on_o & fault)
            pf_flag_o <= 1'b1;
         else if (standby)
            pf_flag_o <= 1'b0;
         if (~on_o & ~standby & ol_evt_i)
            ol_flag_o <= 1'b1;
         else if (standby)
            ol_flag_o <= 1'b0;
      end
   end

endmodule : rss_channel

// File: rss_switch_top.sv
// Relay switch serial slave: frame check, mode register, diagnosis
// packing, detector qualification and eight channel controllers.
// Assumes a serial master that obeys the CS lead and lag times and
// analogue detectors that present plain logic levels.
`timescale 1ns/1ps

// Overview of operation
// - CS fall starts frame; sample falling, shift rising
// - Accept word only if clocks multiple of 8, >=16
// - Deselected: ignore SCLK and SI, SO floats
// - CS fall copies diagnosis flags into shifter
// - SO shows error flag OR SI until first rise
// - Any reset sets the error flag
// - Error flag reports whether previous frame was valid
// - Data travels most significant bit first
// - Plain shift register, one bit per clock
// - Reset sets all register bits, device idle
// - Two mode bits per channel, channel 8 highest
// - Mode 00: off, flags cleared, no diagnosis current
// - Mode 01: follows input pin, current when pin low
// - Mode 10: channel forced on
// - Mode 11: off with diagnosis current
// - All channels standby puts device to sleep
// - Open-load on odd bits, fault on even
// - Open-load flag set only while channel off
// - Fault flag set on shutdown while channel on
// - Flags stay latched until channel set standby
// - Faulted channel stays off until flag cleared
module rss_switch_top
   import rss_pkg::*;
#(
   parameter int unsigned OVL_DELAY_CYC = OVL_CYC,
   parameter int unsigned OL_DELAY_CYC  = OL_CYC
)
(
   // Core clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   // Serial link
   input  wire logic              sclk_i,
   input  wire logic              cs_n_i,
   input  wire logic              si_i,
   output logic                   so_o,
   output logic                   so_oe_o,
   // Channel inputs and detectors
   input  wire logic [CH_NUM-1:0] in_pin_i,
   input  wire logic [CH_NUM-1:0] ovl_det_i,
   input  wire logic [CH_NUM-1:0] ot_det_i,
   input  wire logic [CH_NUM-1:0] ol_det_i,
   // Channel state
   output logic      [CH_NUM-1:0] ch_on_o,
   output logic      [CH_NUM-1:0] diag_cur_o,
   output logic                   sleep_o
);

   localparam int unsigned SYNC_W = 2 + 4 * CH_NUM;
   localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};

   // Elaboration checks
   if (OVL_DELAY_CYC < 1 || OVL_DELAY_CYC >= (1 << DLY_W))
   begin : g_chk_ovl
      $error("OVL_DELAY_CYC out of range");
   end
   if (OL_DELAY_CYC < 1 || OL_DELAY_CYC >= (1 << DLY_W))
   begin : g_chk_ol
      $error("OL_DELAY_CYC out of range");
   end
   if (REG_W != MODE_W * CH_NUM)
   begin : g_chk_w
      $error("register width does not match channel count");
   end
   // The frame counter only wraps correctly inside one unit above the minimum
   if (CNT_MIN != FRAME_MIN || CNT_WRAP != FRAME_MIN + FRAME_UNIT - 1)
   begin : g_chk_cnt
      $error("frame counter limits do not match the length rule");
   end
   if (FRAME_MIN + FRAME_UNIT > (1 << CNT_W))
   begin : g_chk_cnt_w
      $error("frame counter too narrow");
   end
   if (FRAME_MIN != REG_W)
   begin : g_chk_min
      $error("minimum frame differs from register width");
   end
   if (OL_OFS >= MODE_W || PF_OFS >= MODE_W || OL_OFS == PF_OFS)
   begin : g_chk_ofs
      $error("diagnosis flag offsets do not fit a channel pair");
   end
   if (MODE_RST != {REG_W{1'b1}} || SR_RST != {REG_W{1'b1}} || TER_RST != 1'b1)
   begin : g_chk_rst
      $error("reset values must leave every register bit set");
   end

   localparam logic [DLY_W-1:0] OVL_LIM = DLY_W'(OVL_DELAY_CYC);
   localparam logic [DLY_W-1:0] OL_LIM  = DLY_W'(OL_DELAY_CYC);

   // Packs the two flags of each channel into the readout word
   function automatic logic [REG_W-1:0] pack_diag
   (
      input logic [CH_NUM-1:0] ol,
      input logic [CH_NUM-1:0] pf
   );
      logic [REG_W-1:0] w;
      w = '0;
      for (int n = 0; n < CH_NUM; n++)
      begin
         w[MODE_W*n + OL_OFS] = ol[n];
         w[MODE_W*n + PF_OFS] = pf[n];
      end
      return w;
   endfunction : pack_diag

   // True when every channel field holds the standby code
   function automatic logic all_standby
   (
      input logic [REG_W-1:0] m
   );
      logic r;
      r = 1'b1;
      for (int n = 0; n < CH_NUM; n++)
      begin
         if (m[MODE_W*n +: MODE_W] != MODE_STANDBY)
            r = 1'b0;
      end
      return r;
   endfunction : all_standby

   // Declarations
   rss_link_if lnk ();

   rss_frame_e           state_q;
   logic [SYNC_W-1:0]    raw;
   logic [SYNC_W-1:0]    meta_q;
   logic [SYNC_W-1:0]    sync_q;
   logic                 cs_n_s;
   logic                 tog_s;
   logic [CH_NUM-1:0]    in_s;
   logic [CH_NUM-1:0]    ovl_s;
   logic [CH_NUM-1:0]    ot_s;
   logic [CH_NUM-1:0]    ol_s;
   logic                 tog_start_q;
   logic [REG_W-1:0]     rx_q;
   logic [CNT_W-1:0]     cnt_seen_q;
   logic                 tog_seen_q;
   logic                 len_ok;
   logic [REG_W-1:0]     mode_q;
   logic                 ter_q;
   logic [REG_W-1:0]     diag_q;
   logic                 sleep_q;
   logic [CH_NUM-1:0]    ovl_evt;
   logic [CH_NUM-1:0]    ol_evt;
   logic [CH_NUM-1:0]    ol_flag;
   logic [CH_NUM-1:0]    pf_flag;
   logic [DLY_W-1:0]     ovl_cnt_q [CH_NUM];
   logic [DLY_W-1:0]     ol_cnt_q  [CH_NUM];

   // Pin and cross-domain synchronisers
   assign raw = {cs_n_i, lnk.start_tog, in_pin_i, ovl_det_i, ot_det_i, ol_det_i};

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
      end
      else
      begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   assign cs_n_s = sync_q[SYNC_W-1];
   assign tog_s  = sync_q[SYNC_W-2];
   assign in_s   = sync_q[4*CH_NUM-1 -: CH_NUM];
   assign ovl_s  = sync_q[3*CH_NUM-1 -: CH_NUM];
   assign ot_s   = sync_q[2*CH_NUM-1 -: CH_NUM];
   assign ol_s   = sync_q[CH_NUM-1 -: CH_NUM];

   // Serial-clock logic
   rss_link u_link
   (
      .sclk_i  (sclk_i),
      .cs_n_i  (cs_n_i),
      .si_i    (si_i),
      .rst_i   (rst_i),
      .lnk     (lnk),
      .so_o    (so_o),
      .so_oe_o (so_oe_o)
   );

   // Frame tracking
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_q <= RSS_ST_IDLE;
      else
      begin
         case (state_q)
            RSS_ST_IDLE:
            begin
               if (!cs_n_s)
                  state_q <= RSS_ST_FRAME;
            end
            RSS_ST_FRAME:
            begin
               if (cs_n_s)
                  state_q <= RSS_ST_CHECK;
            end
            RSS_ST_CHECK:
               state_q <= RSS_ST_IDLE;
            default:
               state_q <= RSS_ST_IDLE;
         endcase
      end
   end

   // Toggle value at frame start tells a clockless frame from a stale count
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         tog_start_q <= 1'b0;
      else if (state_q == RSS_ST_IDLE)
         tog_start_q <= tog_s;
   end

   // Word, count and toggle are copied on the third core edge after CS rose,
   // once SCLK has been quiet long enough for all of them to settle
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rx_q       <= MODE_RST;
         cnt_seen_q <= '0;
         tog_seen_q <= 1'b0;
      end
      else if (state_q == RSS_ST_FRAME && cs_n_s)
      begin
         rx_q       <= lnk.rx_word;
         cnt_seen_q <= lnk.bit_cnt;
         tog_seen_q <= tog_s;
      end
   end

   assign len_ok = (tog_seen_q != tog_start_q) && (cnt_seen_q == CNT_MIN);

   // Mode register, written only by a valid frame
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         mode_q <= MODE_RST;
      else if (state_q == RSS_ST_CHECK && len_ok)
         mode_q <= rx_q;
   end

   // Transfer error flag
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ter_q <= TER_RST;
      else if (state_q == RSS_ST_CHECK)
         ter_q <= ~len_ok;
   end

   // Diagnosis snapshot frozen for the whole frame
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         diag_q <= '0;
      else if (state_q == RSS_ST_IDLE)
         diag_q <= pack_diag(ol_flag, pf_flag);
   end

   assign lnk.diag_word = diag_q;
   assign lnk.transfer_fault_flag       = ter_q;

   // Sleep when every channel is in standby
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         sleep_q <= 1'b0;
      else
         sleep_q <= all_standby(mode_q);
   end

   assign sleep_o = sleep_q;

   // Per-channel detector filters and controllers
   for (genvar i = 0; i < CH_NUM; i++)
   begin : g_ch
      // Overload must persist while on before the channel is shut down
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
         if (rst_i)
            ovl_cnt_q[i] <= '0;
         else if (ovl_s[i] && ch_on_o[i])
         begin
            if (ovl_cnt_q[i] != OVL_LIM)
               ovl_cnt_q[i] <= ovl_cnt_q[i] + 1'b1;
         end
         else
            ovl_cnt_q[i] <= '0;
      end

      // Open load must persist while off with current enabled
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
         if (rst_i)
            ol_cnt_q[i] <= '0;
         else if (ol_s[i] && !ch_on_o[i] && diag_cur_o[i])
         begin
            if (ol_cnt_q[i] != OL_LIM)
               ol_cnt_q[i] <= ol_cnt_q[i] + 1'b1;
         end
         else
            ol_cnt_q[i] <= '0;
      end

      assign ovl_evt[i] = (ovl_cnt_q[i] == OVL_LIM);
      assign ol_evt[i]  = (ol_cnt_q[i] == OL_LIM);

      rss_channel u_ch
      (
         .clk_i      (core_clk_i),
         .rst_i      (rst_i),
         .mode_i     (mode_q[MODE_W*i +: MODE_W]),
         .in_pin_i   (in_s[i]),
         .ovl_evt_i  (ovl_evt[i]),
         .ot_evt_i   (ot_s[i]),
         .ol_evt_i   (ol_evt[i]),
         .on_o       (ch_on_o[i]),
         .diag_cur_o (diag_cur_o[i]),
         .ol_flag_o  (ol_flag[i]),
         .pf_flag_o  (pf_flag[i])
      );
   end

endmodule : rss_switch_top

// File: rss_switch_chk.sv
// Port-level checks on the relay switch serial slave.
// Assumes the bench holds the detector inputs low during reset.
`timescale 1ns/1ps
module rss_switch_chk
   import rss_pkg::*;
#(
   parameter int unsigned OVL_DELAY_CYC = OVL_CYC,
   parameter int unsigned OL_DELAY_CYC  = OL_CYC
)
(
   // Clock and reset
   input wire logic              core_clk_i,
   input wire logic              rst_i,
   // Serial link
   input wire logic              sclk_i,
   input wire logic              cs_n_i,
   input wire logic              si_i,
   input wire logic              so_o,
   input wire logic              so_oe_o,
   // Channels
   input wire logic [CH_NUM-1:0] in_pin_i,
   input wire logic [CH_NUM-1:0] ovl_det_i,
   input wire logic [CH_NUM-1:0] ot_det_i,
   input wire logic [CH_NUM-1:0] ol_det_i,
   input wire logic [CH_NUM-1:0] ch_on_o,
   input wire logic [CH_NUM-1:0] diag_cur_o,
   input wire logic              sleep_o
);
   logic first_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // Marks the first frame after any reset
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         first_q <= 1'b1;
      else if (!cs_n_i)
         first_q <= 1'b0;
   end

   property p_oe;
      so_oe_o == !cs_n_i;
   endproperty
   a_oe: assert property (p_oe)
      else $error("data out enable does not follow select");
   property p_start;
      $fell(cs_n_i) && si_i |-> so_o;
   endproperty
   a_start: assert property (p_start)
      else $error("frame start bit lost the data-in level");
   property p_first;
      first_q && $fell(cs_n_i) |-> so_o;
   endproperty
   a_first: assert property (p_first)
      else $error("first frame after reset shows no error");
   // Shifting happens on the rising edge only
   property p_hold;
      !cs_n_i && sclk_i && $past(sclk_i) |-> $stable(so_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("data out moved while serial clock high");
   property p_rst;
      $fell(rst_i) |=> diag_cur_o == 8'hff && ch_on_o == 8'h00 && !sleep_o;
   endproperty
   a_rst: assert property (p_rst)
      else $error("state after reset is not all-off idle");
   // Six samples of heat leave room for two sync stages and the latch
   property p_ot;
      (ot_det_i & $past(ot_det_i, 1) & $past(ot_det_i, 2) & $past(ot_det_i, 3)
       & $past(ot_det_i, 4) & $past(ot_det_i, 5) & ch_on_o) == 8'h00;
   endproperty
   a_ot: assert property (p_ot)
      else $error("channel stayed on under overtemperature");
   property p_sleep;
      $rose(sleep_o) |-> ##[0:2] (ch_on_o == 8'h00 && diag_cur_o == 8'h00);
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep with a channel still active");
   property p_sleep_cs;
      $rose(sleep_o) |-> cs_n_i && $past(cs_n_i, 2);
   endproperty
   a_sleep_cs: assert property (p_sleep_cs)
      else $error("mode changed inside a frame");

   c_frame: cover property ($fell(cs_n_i));
   c_sleep: cover property ($rose(sleep_o));
   c_trip:  cover property ($fell(ch_on_o[4]));
endmodule : rss_switch_chk

bind rss_switch_top rss_switch_chk #(
   .OVL_DELAY_CYC (OVL_DELAY_CYC),
   .OL_DELAY_CYC  (OL_DELAY_CYC)
) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
   .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .in_pin_i(in_pin_i),
   .ovl_det_i(ovl_det_i), .ot_det_i(ot_det_i), .ol_det_i(ol_det_i),
   .ch_on_o(ch_on_o), .diag_cur_o(diag_cur_o), .sleep_o(sleep_o));

// File: rss_host_model.sv
// Serial host model: drives select, serial clock and data in.
// Assumes the bench floats the data-out wire while it is not enabled.
`timescale 1ns/1ps
module rss_host_model
(
   // Serial pins
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      si_o,
   input  wire logic so_i
);
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end

   // The clock runs only inside the frame, exactly n pulses
   task automatic xfer(input int n, input logic [31:0] d,
                       output logic [31:0] q, output logic f);
      int i;
      q = '0;
      #7;
      si_o = d[n-1];
      cs_n_o = 1'b0;
      #300;
      f = so_i;
      for (i = n - 1; i >= 0; i--)
      begin
         #20 si_o = d[i];
         #60 sclk_o = 1'b1;
         #79 q = {q[30:0], so_i};
         #1 sclk_o = 1'b0;
      end
      #300 cs_n_o = 1'b1;
      // Released data-in falls to its pull-down level
      si_o = 1'b0;
      #300;
   endtask : xfer
endmodule : rss_host_model

// File: tb_relay_switch_spi_slave.sv
// Bench for the relay switch serial slave: frames, modes and faults.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_relay_switch_spi_slave;
   import rss_pkg::*;

   logic              core_clk_i;
   logic              rst_i;
   logic              sclk;
   logic              cs_n;
   logic              si;
   logic              so;
   logic              so_oe;
   wire               so_w;
   logic [CH_NUM-1:0] in_pin;
   logic [CH_NUM-1:0] ovl;
   logic [CH_NUM-1:0] ot;
   logic [CH_NUM-1:0] ol;
   logic [CH_NUM-1:0] ch_on;
   logic [CH_NUM-1:0] diag_cur;
   logic              sleep;
   logic [31:0]       q;
   logic              f;
   int                n_fail;
   int                comparisons;

   // Floating data out reads as Z, so a stale bit cannot match
   assign so_w = so_oe ? so : 1'bz;

   rss_switch_top #(.OVL_DELAY_CYC(2), .OL_DELAY_CYC(4)) dut
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .sclk_i     (sclk),
      .cs_n_i     (cs_n),
      .si_i       (si),
      .so_o       (so),
      .so_oe_o    (so_oe),
      .in_pin_i   (in_pin),
      .ovl_det_i  (ovl),
      .ot_det_i   (ot),
      .ol_det_i   (ol),
      .ch_on_o    (ch_on),
      .diag_cur_o (diag_cur),
      .sleep_o    (sleep)
   );

   rss_host_model mst (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_w));

   initial
   begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #2;
   endtask : cyc

   task automatic frame(input int n, input logic [31:0] d,
                        input logic ef, input logic [31:0] eq);
      mst.xfer(n, d, q, f);
      check(32'(f), 32'(ef));
      check(q, eq);
   endtask : frame

   task automatic wait_off(input logic [7:0] m);
      int i;
      for (i = 0; i < 50 && (ch_on & m) !== 8'h00; i++)
         cyc(1);
      if (i == 50)
      begin
         n_fail++;
         conclude();
      end
   endtask : wait_off

   initial
   begin
      #1000000;
      n_fail++;
      conclude();
   end

   initial
   begin
      n_fail = 0;
      comparisons = 0;
      rst_i = 1'b1;
      in_pin = '0;
      ovl = '0;
      ot = '0;
      ol = '0;
      cyc(12);
      rst_i = 1'b0;
      cyc(3);
      check(32'(ch_on), 32'h0);
      check(32'(diag_cur), 32'hff);
      check(32'(sleep), 32'h0);
      // Every mode code appears twice in this word
      frame(16, 32'h4e4e, 1'b1, 32'h0);
      check(32'(ch_on), 32'h11);
      check(32'(diag_cur & 8'hee), 32'haa);
      in_pin = 8'h8c;
      cyc(6);
      check(32'(ch_on), 32'h99);
      frame(12, 32'h0, 1'b0, 32'h0);
      check(32'(ch_on), 32'h99);
      frame(24, 32'h5a4e4f, 1'b1, 32'h5a);
      check(32'(ch_on), 32'h98);
      ovl = 8'h10;
      ot = 8'h80;
      wait_off(8'h90);
      check(32'(ch_on & 8'h90), 32'h0);
      cyc(1);
      ovl = '0;
      ot = '0;
      ol = 8'h06;
      cyc(20);
      ol = '0;
      cyc(4);
      check(32'(ch_on), 32'h08);
      frame(16, 32'h4e4f, 1'b0, 32'h4108);
      frame(16, 32'h0, 1'b0, 32'h4108);
      check(32'(sleep), 32'h1);
      check(32'({ch_on, diag_cur}), 32'h0);
      frame(16, 32'h4e4e, 1'b0, 32'h0);
      check(32'({sleep, ch_on}), 32'h99);
      frame(16, 32'hce4e, 1'b1, 32'h0);
      check(32'(ch_on), 32'h19);
      cyc(1);
      rst_i = 1'b1;
      cyc(3);
      rst_i = 1'b0;
      cyc(3);
      frame(16, 32'h4e4e, 1'b1, 32'h0);
      conclude();
   end
endmodule : tb_relay_switch_spi_slave
